// *** core/tms_pkg.sv ***
// Purpose: Shared constants and types for the temperature monitor core.
// Assumes: 200 MHz system clock, synchronous active-low reset.
// Notes:   Register pointers and field positions are named here once.
package tms_pkg;

    // -------------------------------------------------------------
    // Register pointers reached through the serial slave
    // -------------------------------------------------------------
    localparam logic [7:0] PTR_LOCAL_HI    = 8'h00;
    localparam logic [7:0] PTR_REMOTE_HI   = 8'h01;
    localparam logic [7:0] PTR_STATUS      = 8'h02;
    localparam logic [7:0] PTR_CONFIG_RD   = 8'h03;
    localparam logic [7:0] PTR_CONFIG_WR   = 8'h09;
    localparam logic [7:0] PTR_RLIM_HI_RD  = 8'h07;
    localparam logic [7:0] PTR_RLIM_HI_WR  = 8'h0D;
    localparam logic [7:0] PTR_RLIM_LO_RD  = 8'h08;
    localparam logic [7:0] PTR_RLIM_LO_WR  = 8'h0E;
    localparam logic [7:0] PTR_REMOTE_LO   = 8'h10;
    localparam logic [7:0] PTR_LOCAL_LO    = 8'h15;
    localparam logic [7:0] PTR_FILTER      = 8'h24;
    localparam logic [7:0] PTR_CONSEC      = 8'h22;

    // -------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------
    localparam int         CFG_POWER_DOWN_BIT = 6;
    localparam int         STAT_OPEN_BIT      = 2;
    localparam int         STAT_BUSY_BIT      = 7;
    localparam logic [7:0] CONFIG_RESET       = 8'h00;
    localparam logic [7:0] RLIM_HI_RESET      = 8'h55;
    localparam logic [7:0] RLIM_LO_RESET      = 8'h00;
    localparam logic [2:0] CONSEC_RESET       = 3'h0;
    localparam logic [1:0] FILTER_RESET       = 2'h0;
    localparam logic [7:0] SHORTED_READING    = 8'hC0;
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ         = 200;
    localparam int CONV_TIME_US    = 100;
    localparam int CONV_CYCLES     = CONV_TIME_US * CLK_MHZ;

    // Filter level encodings.
    typedef enum logic [1:0] {
        TMS_FILT_OFF = 2'h0,
        TMS_FILT_4   = 2'h1,
        TMS_FILT_8   = 2'h2
    } tms_filt_t;

    // One finished sample handed from the analog front end.
    typedef struct packed {
        logic [7:0] whole;
        logic [3:0] frac;
    } tms_temp_t;

    // One register access request from the serial slave.
    typedef struct packed {
        logic       wr;
        logic [7:0] ptr;
        logic [7:0] data;
    } tms_reg_req_t;

endpackage : tms_pkg

// *** core/tms_i2c_slave.sv ***
// Purpose: Two-wire serial slave that reaches the register file.
// Assumes: Pins are sampled by two flops on clk_sys before use.
// Notes:   Slave only; the master owns the clock and all conditions.
`timescale 1ns/1ps
module tms_i2c_slave (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [6:0]            slave_addr,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    output tms_pkg::tms_reg_req_t      req,
    output logic                       req_valid,
    input  wire logic [7:0]            rd_data
);
    import tms_pkg::*;

    // -------------------------------------------------------------
    // Pin synchronisers and edge detection
    // -------------------------------------------------------------
    logic [1:0] scl_s_r, sda_s_r;  // Two-flop synchronisers.
    logic       scl_d_r, sda_d_r;  // Delayed copies for edges.
    // sync latency bounds bus rate
    // Three cycles of latency stay far below a high phase at 2.5 MHz.
    always_ff @(posedge clk_sys) begin
        scl_s_r <= {scl_s_r[0], scl_i};
        sda_s_r <= {sda_s_r[0], sda_i};
        scl_d_r <= scl_s_r[1];
        sda_d_r <= sda_s_r[1];
    end
    wire scl_rise = scl_s_r[1] & ~scl_d_r;
    wire scl_fall = ~scl_s_r[1] & scl_d_r;
    wire start_ev = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
    wire stop_ev  = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA} tms_st_t;
    tms_st_t    st_r, st_nxt;         // Transaction phase.
    logic [3:0] bit_r, bit_nxt;       // Bit count within byte, 8 = ack slot.
    logic [7:0] sh_r, sh_nxt;         // Shift register.
    logic       ack_r, ack_nxt;       // Drive ack low during ninth clock.
    logic       tx_r, tx_nxt;         // Drive read data.
    logic       nack_r, nack_nxt;     // Master declined further bytes.
    logic [7:0] ptr_r, ptr_nxt;       // Register pointer, persists.
    logic       rv_nxt;
    tms_reg_req_t req_nxt;

    // -------------------------------------------------------------
    // Next-state logic of the byte engine
    // -------------------------------------------------------------
    always_comb begin
        st_nxt = st_r; bit_nxt = bit_r; sh_nxt = sh_r; ack_nxt = ack_r;
        tx_nxt = tx_r; nack_nxt = nack_r; ptr_nxt = ptr_r;
        rv_nxt = 1'b0; req_nxt = req;
        if (start_ev) begin
            // The clock fall that follows a start carries no bit, so the count
            // is parked one below zero and that fall wraps it to zero.
            st_nxt = ST_ADDR; bit_nxt = 4'hF; ack_nxt = 1'b0; tx_nxt = 1'b0;
        end else if (stop_ev) begin
            st_nxt = ST_IDLE; ack_nxt = 1'b0; tx_nxt = 1'b0;
        end else if (st_r != ST_IDLE && st_r != ST_RDATA && scl_rise && bit_r < 4'h8) begin
            // While transmitting, the shifter moves only on the falling clock.
            // shift in msb first
            sh_nxt = {sh_r[6:0], sda_s_r[1]};
        end else if (st_r == ST_RDATA && scl_rise && bit_r == 4'h8) begin
            nack_nxt = sda_s_r[1];
        end else if (st_r != ST_IDLE && scl_fall) begin
            if (bit_r == 4'h7) begin
                bit_nxt = 4'h8;
                tx_nxt = 1'b0;
                unique case (st_r)
                    ST_ADDR: begin
                        ack_nxt = (sh_r[7:1] == slave_addr);
                        if (sh_r[7:1] != slave_addr) st_nxt = ST_IDLE;
                    end
                    ST_PTR: begin
                        ack_nxt = 1'b1; ptr_nxt = sh_r;
                    end
                    ST_WDATA: begin
                        ack_nxt = 1'b1; rv_nxt = 1'b1;
                        req_nxt = '{wr: 1'b1, ptr: ptr_r, data: sh_r};
                    end
                    default: ack_nxt = 1'b0;
                endcase
            end else if (bit_r == 4'h8) begin
                bit_nxt = 4'h0; ack_nxt = 1'b0;
                if (st_r == ST_ADDR) begin
                    st_nxt = sh_r[0] ? ST_RDATA : ST_PTR;
                    if (sh_r[0]) begin
                        sh_nxt = rd_data; tx_nxt = 1'b1; nack_nxt = 1'b0;
                    end
                end else if (st_r == ST_PTR) begin
                    st_nxt = ST_WDATA;
                end else if (st_r == ST_RDATA) begin
                    if (nack_r) st_nxt = ST_IDLE;
                    else begin
                        sh_nxt = rd_data; tx_nxt = 1'b1;
                    end
                end
            end else begin
                bit_nxt = bit_r + 4'h1;
                if (st_r == ST_RDATA) sh_nxt = {sh_r[6:0], 1'b0};
            end
        end
    end

    // -------------------------------------------------------------
    // State registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= ST_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; ack_r <= 1'b0;
            tx_r <= 1'b0; nack_r <= 1'b0; ptr_r <= 8'h00;
            req <= '0; req_valid <= 1'b0;
        end else begin
            st_r <= st_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; ack_r <= ack_nxt;
            tx_r <= tx_nxt; nack_r <= nack_nxt; ptr_r <= ptr_nxt;
            req <= rv_nxt ? req_nxt : '{wr: 1'b0, ptr: ptr_r, data: 8'h00};
            req_valid <= rv_nxt;
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = ack_r | (tx_r & ~sh_r[7]);

endmodule : tms_i2c_slave

// *** core/tms_core.sv ***
// Purpose: Temperature monitor digital core with serial register access.
// Assumes: Analog front end delivers samples with a done strobe.
// Notes:   Remote channel has the optional moving-average filter.
//
// Contract
// - integer byte, eight bits, msb clear positive
// - fraction byte uses bits seven to four
// - filter averages last four or eight
// - result and limits use filtered value
// - filter off at reset, set by register
// - shorted sensor reports minus sixty-four
// - fault during conversion sets open flag
// - violation count field sets alarm qualifier
// - power down after current conversion ends
// - otherwise convert continuously, self triggered
// - serial side acts only as slave
// - fast and high speed bus rates
// - bytes shifted msb first
// - start and stop by sda while scl high
// - acknowledge own address on ninth clock
// - eight data pulses then acknowledge
// - any number of bytes per transaction
// - restart or stop returns to addressing
// - first written byte loads pointer
// - reads use most recent pointer
`timescale 1ns/1ps
module tms_core (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [6:0]        slave_addr,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    output logic                   conv_start,
    input  wire logic              conv_done,
    input  wire tms_pkg::tms_temp_t local_sample,
    input  wire tms_pkg::tms_temp_t remote_sample,
    input  wire logic              fault_cmp,
    input  wire logic              remote_short,
    output logic                   analog_power_on,
    output logic                   overtemp_pin_n
);
    import tms_pkg::*;

    // -------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------
    logic [7:0]  config_r, config_nxt;         // Configuration byte.
    logic [7:0]  rlim_hi_r, rlim_hi_nxt;       // Remote high limit.
    logic [7:0]  rlim_lo_r, rlim_lo_nxt;       // Remote low limit.
    logic [2:0]  violation_count_field_r, vcf_nxt; // Alarm qualifier.
    tms_filt_t   filt_r, filt_nxt;             // Filter level.
    logic        open_r, open_nxt;             // Open-circuit flag.
    tms_temp_t   local_r, local_nxt;           // Local result.
    tms_temp_t   remote_r, remote_nxt;         // Filtered remote result.
    logic        busy_r, busy_nxt;             // Conversion running.
    logic        fault_seen_r, fault_seen_nxt; // Fault within this conversion.
    logic [2:0]  viol_cnt_r, viol_cnt_nxt;     // Consecutive violations.
    logic        alarm_r, alarm_nxt;           // Alarm state.
    logic [11:0] hist_r [8];                   // Remote sample history.
    logic [3:0]  fill_r, fill_nxt;             // Valid history entries.
    logic        fsync_r [2];                  // Synchronised fault input.
    logic [7:0]  rd_data;                      // Selected read byte.

    tms_reg_req_t req;
    logic         req_valid;

    // -------------------------------------------------------------
    // Serial slave
    // -------------------------------------------------------------
    tms_i2c_slave u_slave (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .slave_addr (slave_addr),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe     (sda_oe),
        .req        (req),
        .req_valid  (req_valid),
        .rd_data    (rd_data)
    );

    // Fault comparator comes from the analog side; sync it.
    always_ff @(posedge clk_sys) begin
        fsync_r[0] <= fault_cmp;
        fsync_r[1] <= fsync_r[0];
    end

    // -------------------------------------------------------------
    // Remote filter: sum of newest samples
    // -------------------------------------------------------------
    logic [11:0] raw_remote;    // Raw sample, short substituted.
    logic [14:0] sum4, sum8;    // Running sums.
    logic [11:0] filt_out;      // Filter output.
    always_comb begin
        raw_remote = remote_short ? {SHORTED_READING, 4'h0}
                                  : {remote_sample.whole, remote_sample.frac};
        sum4 = 15'(raw_remote);
        sum8 = 15'(raw_remote);
        for (int i = 0; i < 7; i++) begin
            if (i < 3) sum4 = sum4 + 15'(hist_r[i]);
            sum8 = sum8 + 15'(hist_r[i]);
        end
        unique case (filt_r)
            TMS_FILT_4: filt_out = (fill_r >= 4'h3) ? sum4[13:2] : raw_remote;
            TMS_FILT_8: filt_out = (fill_r >= 4'h7) ? sum8[14:3] : raw_remote;
            default:    filt_out = raw_remote;
        endcase
    end

    // -------------------------------------------------------------
    // Conversion, status and alarm next values
    // -------------------------------------------------------------
    logic viol;  // Filtered remote outside limits.
    always_comb begin
        config_nxt = config_r; rlim_hi_nxt = rlim_hi_r; rlim_lo_nxt = rlim_lo_r;
        vcf_nxt = violation_count_field_r; filt_nxt = filt_r; open_nxt = open_r;
        local_nxt = local_r; remote_nxt = remote_r; busy_nxt = busy_r;
        fault_seen_nxt = fault_seen_r; viol_cnt_nxt = viol_cnt_r;
        alarm_nxt = alarm_r; fill_nxt = fill_r; conv_start = 1'b0;
        viol = (filt_out[11:4] > rlim_hi_r) || (filt_out[11:4] < rlim_lo_r);
        if (req_valid) begin
            unique case (req.ptr)
                PTR_CONFIG_WR:  config_nxt = req.data;
                PTR_RLIM_HI_WR: rlim_hi_nxt = req.data;
                PTR_RLIM_LO_WR: rlim_lo_nxt = req.data;
                PTR_CONSEC:     vcf_nxt = req.data[2:0];
                PTR_FILTER: begin
                    filt_nxt = tms_filt_t'(req.data[1:0] == 2'h3 ? 2'h0 : req.data[1:0]);
                    fill_nxt = 4'h0;
                end
                default: ;
            endcase
        end
        if (busy_r && fsync_r[1]) fault_seen_nxt = 1'b1;
        if (busy_r && conv_done) begin
            busy_nxt = 1'b0;
            open_nxt = fault_seen_r | fsync_r[1];
            fault_seen_nxt = 1'b0;
            local_nxt = local_sample;
            remote_nxt = '{whole: filt_out[11:4], frac: filt_out[3:0]};
            if (fill_nxt < 4'h8 && !(req_valid && req.ptr == PTR_FILTER))
                fill_nxt = fill_r + 4'h1;
            if (viol) begin
                if (viol_cnt_r != 3'h7) viol_cnt_nxt = viol_cnt_r + 3'h1;
                // Widened so that a saturated count of seven does not wrap.
                alarm_nxt = (4'(viol_cnt_r) + 4'h1) >=
                            (4'h1 + 4'(violation_count_field_r[0])
                                  + 4'(violation_count_field_r[1])
                                  + 4'(violation_count_field_r[2]));
            end else begin
                viol_cnt_nxt = 3'h0;
                alarm_nxt = 1'b0;
            end
        end else if (!busy_r && !config_r[CFG_POWER_DOWN_BIT]) begin
            busy_nxt = 1'b1;
            conv_start = 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            config_r <= CONFIG_RESET; rlim_hi_r <= RLIM_HI_RESET;
            rlim_lo_r <= RLIM_LO_RESET; violation_count_field_r <= CONSEC_RESET;
            filt_r <= tms_filt_t'(FILTER_RESET);
            open_r <= 1'b0; local_r <= '0; remote_r <= '0; busy_r <= 1'b0;
            fault_seen_r <= 1'b0; viol_cnt_r <= 3'h0; alarm_r <= 1'b0;
            fill_r <= 4'h0;
        end else begin
            config_r <= config_nxt; rlim_hi_r <= rlim_hi_nxt;
            rlim_lo_r <= rlim_lo_nxt; violation_count_field_r <= vcf_nxt;
            filt_r <= filt_nxt; open_r <= open_nxt; local_r <= local_nxt;
            remote_r <= remote_nxt; busy_r <= busy_nxt;
            fault_seen_r <= fault_seen_nxt; viol_cnt_r <= viol_cnt_nxt;
            alarm_r <= alarm_nxt; fill_r <= fill_nxt;
        end
    end

    // History shifts one place per finished conversion, per entry.
    for (genvar g = 0; g < 8; g++) begin : g_hist
        always_ff @(posedge clk_sys) begin
            if (!rst_n) hist_r[g] <= 12'h000;
            else if (busy_r && conv_done)
                hist_r[g] <= (g == 0) ? raw_remote : hist_r[(g == 0) ? 0 : g - 1];
        end
    end

    assign analog_power_on = busy_r | ~config_r[CFG_POWER_DOWN_BIT];
    assign overtemp_pin_n  = ~alarm_r;

    // -------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------
    always_comb begin
        unique case (req.ptr)
            PTR_LOCAL_HI:   rd_data = local_r.whole;
            PTR_REMOTE_HI:  rd_data = remote_r.whole;
            PTR_STATUS:     rd_data = {busy_r, 4'h0, open_r, 2'h0};
            PTR_CONFIG_RD:  rd_data = config_r;
            PTR_RLIM_HI_RD: rd_data = rlim_hi_r;
            PTR_RLIM_LO_RD: rd_data = rlim_lo_r;
            PTR_REMOTE_LO:  rd_data = {remote_r.frac, 4'h0};
            PTR_LOCAL_LO:   rd_data = {local_r.frac, 4'h0};
            PTR_CONSEC:     rd_data = {5'h00, violation_count_field_r};
            PTR_FILTER:     rd_data = {6'h00, filt_r};
            default:        rd_data = 8'h00;
        endcase
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    chk_short_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (busy_r && conv_done && remote_short && filt_r == TMS_FILT_OFF)
        |=> remote_r.whole == SHORTED_READING) else $error("short value wrong");
    chk_open_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (busy_r && conv_done && fault_seen_r) |=> open_r) else $error("open flag not set");
    chk_no_start_pd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        config_r[CFG_POWER_DOWN_BIT] |-> !conv_start) else $error("start in power down");
    chk_cont_conv: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!busy_r && !config_r[CFG_POWER_DOWN_BIT]) |=> busy_r) else $error("no restart");
    chk_single_alarm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (busy_r && conv_done && viol && violation_count_field_r == 3'h0) |=> alarm_r)
        else $error("alarm not raised");
    chk_alarm_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (busy_r && conv_done && !viol) |=> !alarm_r && viol_cnt_r == 3'h0)
        else $error("alarm not cleared");
    chk_alarm_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (busy_r && conv_done && viol && viol_cnt_r == 3'h7) |=> alarm_r)
        else $error("alarm dropped at saturation");
    chk_four_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (busy_r && conv_done && viol && viol_cnt_r == 3'h0
         && violation_count_field_r == 3'h7) |=> !alarm_r)
        else $error("alarm before fourth violation");
    chk_filt_hist: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req_valid && req.ptr == PTR_FILTER) |=> fill_r == 4'h0) else $error("history kept");
    chk_frac_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req.ptr == PTR_REMOTE_LO) |-> rd_data[3:0] == 4'h0) else $error("fraction low bits");

endmodule : tms_core

// *** testbench/tms_bus_master.sv ***
// Purpose: Bus master model that owns the two-wire clock and conditions.
// Assumes: Both lines have pull-ups; a released data line reads high.
// Notes:   The clock high phase is H system cycles and the low phase H+2.
`timescale 1ns/1ps
module tms_bus_master #(
    parameter int H = 6
) (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // one clock pulse
    // Data changes only while the clock is low and is sampled mid-high.
    task automatic pulse(input logic v, output logic s);
        sda <= v;
        repeat (H) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (H / 2) @(posedge clk_sys);
        s = sda_line;
        repeat (H / 2) @(posedge clk_sys);
        scl <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : pulse

    task automatic start();
        sda <= 1'b1;
        repeat (H) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (H) @(posedge clk_sys);
        sda <= 1'b0;
        repeat (H) @(posedge clk_sys);
        scl <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : start

    task automatic stop();
        sda <= 1'b0;
        repeat (H) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (H) @(posedge clk_sys);
        sda <= 1'b1;
        repeat (H) @(posedge clk_sys);
    endtask : stop
endmodule : tms_bus_master

// *** testbench/tb_temp_monitor_core_serial_slave.sv ***
// Purpose: Self-checking bench for the monitor core through its serial slave.
// Assumes: Front end answers each conversion start on the next cycle.
// Notes:   Register access is by two-wire transactions only.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb_temp_monitor_core_serial_slave;
    import tms_pkg::*;
    localparam logic [6:0] ADDR = 7'h2A;    // Own address for this run.
    logic clk_sys = 1'b0, rst_n = 1'b0, conv_done = 1'b0;
    logic fault_cmp = 1'b0, remote_short = 1'b0;
    logic scl, sda_m, sda_o, sda_oe, conv_start, analog_power_on, overtemp_pin_n;
    tms_temp_t local_sample = {8'h73, 4'h7}, remote_sample = {8'h19, 4'h8};
    int error_cnt = 0, checked = 0, starts = 0, s0;
    wire sda_line = sda_m & ~sda_oe;         // Pulled-up wired-AND data line.
    always #2.5 clk_sys = ~clk_sys;
    // The front end model finishes one cycle after each start.
    always @(posedge clk_sys) conv_done <= conv_start;
    always @(posedge clk_sys) if (conv_start === 1'b1) starts <= starts + 1;
    tms_bus_master #(.H(6)) m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(sda_m));
    tms_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .slave_addr(ADDR), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .conv_start(conv_start),
        .conv_done(conv_done), .local_sample(local_sample), .remote_sample(remote_sample),
        .fault_cmp(fault_cmp), .remote_short(remote_short),
        .analog_power_on(analog_power_on), .overtemp_pin_n(overtemp_pin_n));

    // Sends one byte and checks the slave's answer in the ninth slot.
    task automatic put(input logic [7:0] b, input logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) m.pulse(b[i], s);
        m.pulse(1'b1, s);
        `CHK(s, nak)
    endtask : put
    // Single-byte read closed by a master not-acknowledge.
    task automatic rd_only(input logic [7:0] e, input logic [7:0] mask);
        logic [7:0] d;
        logic s;
        m.start();
        put({ADDR, 1'b1}, 1'b0);
        for (int i = 7; i >= 0; i--) m.pulse(1'b1, d[i]);
        m.pulse(1'b1, s);
        m.stop();
        `CHK(d & mask, e & mask)
    endtask : rd_only
    task automatic reg_rd(input logic [7:0] p, input logic [7:0] e, input logic [7:0] mask);
        m.start();
        put({ADDR, 1'b0}, 1'b0);
        put(p, 1'b0);
        rd_only(e, mask);
    endtask : reg_rd
    task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
        m.start();
        put({ADDR, 1'b0}, 1'b0);
        put(p, 1'b0);
        put(d, 1'b0);
        m.stop();
    endtask : reg_wr
    task automatic print_verdict();
        $display("mismatches %0d of %0d comparisons", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        `CHK(overtemp_pin_n, 1'b1)
        rst_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reg_rd(PTR_FILTER, 8'h00, 8'h03);
        reg_rd(PTR_CONSEC, 8'h00, 8'hFF);
        reg_rd(PTR_CONFIG_RD, CONFIG_RESET, 8'hFF);
        reg_rd(PTR_REMOTE_HI, 8'h19, 8'hFF);
        reg_rd(PTR_REMOTE_LO, 8'h80, 8'hFF);
        reg_rd(PTR_LOCAL_HI, 8'h73, 8'hFF);
        reg_rd(PTR_LOCAL_LO, 8'h70, 8'hFF);
        m.start();
        put({ADDR ^ 7'h01, 1'b0}, 1'b1);
        m.stop();
        rd_only(8'h70, 8'hFF);
        remote_short <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reg_rd(PTR_REMOTE_HI, SHORTED_READING, 8'hFF);
        remote_short <= 1'b0;
        fault_cmp <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reg_rd(PTR_STATUS, 8'h04, 8'h04);
        fault_cmp <= 1'b0;
        remote_sample <= {8'h60, 4'h0};
        repeat (20) @(posedge clk_sys);
        `CHK(overtemp_pin_n, 1'b0)
        m.start();
        put({ADDR, 1'b0}, 1'b0);
        put(PTR_RLIM_HI_WR, 1'b0);
        put(8'h70, 1'b0);
        put(8'h7F, 1'b0);
        m.stop();
        reg_rd(PTR_RLIM_HI_RD, 8'h7F, 8'hFF);
        repeat (20) @(posedge clk_sys);
        `CHK(overtemp_pin_n, 1'b1)
        reg_wr(PTR_CONSEC, 8'h07);
        reg_rd(PTR_CONSEC, 8'h07, 8'hFF);
        remote_sample <= {8'hA0, 4'h0};
        repeat (20) @(posedge clk_sys);
        `CHK(overtemp_pin_n, 1'b0)
        reg_wr(PTR_FILTER, 8'h02);
        reg_rd(PTR_FILTER, 8'h02, 8'h03);
        reg_wr(PTR_CONFIG_WR, 8'h40);
        repeat (20) @(posedge clk_sys);
        s0 = starts;
        repeat (200) @(posedge clk_sys);
        `CHK(starts - s0, 0)
        `CHK(analog_power_on, 1'b0)
        reg_wr(PTR_CONFIG_WR, 8'h00);
        repeat (20) @(posedge clk_sys);
        `CHK(starts > s0, 1'b1)
        print_verdict();
    end
endmodule : tb_temp_monitor_core_serial_slave
